/* File: logic/ccg_top.sv */
// Functional notes
// R1: Bank count is a parameter, five or ten, two channels per bank.
// R2: Each bank runs as one differential output or two single-ended ones.
// R3: One logic standard per bank, shared by both channels.
// R4: Four slew settings single-ended; low-swing modes force a fixed slew.
// R5: Low-swing modes disengage the internal source termination.
// R6: Polarity per channel single-ended, once per bank when differential.
// R7: Global enable high puts every driver in high impedance.
// R8: Per output: always on, always off, or follow one secondary enable.
// R9: Secondary enable low drives the clock, high gives high impedance.
// R10: The gate input never disables a driver, it only holds a level.
// R11: Gate low holds true outputs low, inverted high; high passes clock.
// R12: Gating switches on the bank clock edge so no runt pulse appears.
// R13: Banks outside the gate group ignore the gate input.
// R14: Gate input is synchronised by two flops per bank.
// R15: Configuration is static and stable during operation.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module ccg_top
    import ccg_pkg::*;
#(
    parameter int NUM_BANKS = 10,
    parameter int SYNC_STAGES = 2
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic GLOBAL_DRIVE_ENABLE_N_I,
    input wire logic SECONDARY_ENABLE_FIRST_N_I,
    input wire logic SECONDARY_ENABLE_SECOND_N_I,
    input wire logic SYNC_CLOCK_HOLD_N_I,
    input wire logic [AXI_ADDR_W-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [AXI_ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [2*NUM_BANKS-1:0] CLK_OUT_O,
    output logic [2*NUM_BANKS-1:0] DRIVE_OE_N_O,
    output logic [4*NUM_BANKS-1:0] SLEW_O,
    output logic [2*NUM_BANKS-1:0] TERM_EN_O
);

    typedef struct packed {
        logic aw_held;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_BANKS-1:0][CFG_W-1:0] cfg;
    } ccg_top_s;

    ccg_top_s s_r;
    ccg_top_s s_nxt;
    logic [NUM_BANKS-1:0] held;
    logic [NUM_BANKS-1:0] hold_sync_n;
    logic do_write;
    logic ar_take;
    logic ar_mapped;

    // ==========================================================
    // Address decode
    function automatic logic bank_hit(input logic [AXI_ADDR_W-1:0] addr);
        logic [AXI_ADDR_W-1:0] rel;
        rel = addr - OFS_BANK_BASE;
        return (addr >= OFS_BANK_BASE) && (addr[1:0] == 2'h0)
            && (int'(rel[AXI_ADDR_W-1:2]) < NUM_BANKS);
    endfunction : bank_hit

    function automatic int bank_idx(input logic [AXI_ADDR_W-1:0] addr);
        logic [AXI_ADDR_W-1:0] rel;
        rel = addr - OFS_BANK_BASE;
        return int'(rel[AXI_ADDR_W-1:2]);
    endfunction : bank_idx

    function automatic logic [CFG_W-1:0] merge_cfg(input logic [CFG_W-1:0] old, input logic [31:0] data,
                                                   input logic [3:0] strb);
        logic [CFG_W-1:0] res;
        res = old;
        for (int b = 0; b < CFG_W / 8; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_cfg

    assign do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign ar_take = ARVALID_I && !s_r.rvalid;
    assign ar_mapped = (ARADDR_I == OFS_DRV_STATUS) || (ARADDR_I == OFS_PIN_STATUS) || bank_hit(ARADDR_I);

    // ==========================================================
    // Register slave
    always_comb begin
        s_nxt = s_r;
        if (AWVALID_I && !s_r.aw_held) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = AWADDR_I;
        end
        if (WVALID_I && !s_r.w_held) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = WDATA_I;
            s_nxt.w_strb = WSTRB_I;
        end
        if (s_r.bvalid && BREADY_I) begin
            s_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (bank_hit(s_r.aw_addr)) begin
                // Meant to be loaded once at bring-up, never while clocks run
                s_nxt.cfg[bank_idx(s_r.aw_addr)] = merge_cfg(s_r.cfg[bank_idx(s_r.aw_addr)],
                                                            s_r.w_data, s_r.w_strb); // R15
            end else if (s_r.aw_addr != OFS_DRV_STATUS && s_r.aw_addr != OFS_PIN_STATUS) begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end
        if (s_r.rvalid && RREADY_I) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ar_take) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = '0;
            s_nxt.rresp = RESP_OKAY;
            if (ARADDR_I == OFS_DRV_STATUS) begin
                s_nxt.rdata[2*NUM_BANKS-1:0] = ~DRIVE_OE_N_O;
            end else if (ARADDR_I == OFS_PIN_STATUS) begin
                s_nxt.rdata[PIN_HOLD_BIT] = SYNC_CLOCK_HOLD_N_I;
                s_nxt.rdata[PIN_GLOBAL_BIT] = GLOBAL_DRIVE_ENABLE_N_I;
                s_nxt.rdata[PIN_FIRST_BIT] = SECONDARY_ENABLE_FIRST_N_I;
                s_nxt.rdata[PIN_SECOND_BIT] = SECONDARY_ENABLE_SECOND_N_I;
                s_nxt.rdata[PIN_HELD_LSB +: NUM_BANKS] = held;
            end else if (bank_hit(ARADDR_I)) begin
                s_nxt.rdata[CFG_W-1:0] = s_r.cfg[bank_idx(ARADDR_I)];
            end else begin
                s_nxt.rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s_r <= '0;
            s_r.cfg <= {NUM_BANKS{CFG_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign AWREADY_O = !s_r.aw_held;
    assign WREADY_O = !s_r.w_held;
    assign BVALID_O = s_r.bvalid;
    assign BRESP_O = s_r.bresp;
    assign ARREADY_O = !s_r.rvalid;
    assign RVALID_O = s_r.rvalid;
    assign RDATA_O = s_r.rdata;
    assign RRESP_O = s_r.rresp;

    // ==========================================================
    // Output banks
    // One synchroniser per bank keeps each hold local to its own clock tree
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank // R1
        ccg_sync #(
            .STAGES(SYNC_STAGES)
        ) u_sync (
            .clk_i(CLK_I),
            .rst_n_i(RSTN_I),
            .d_i(SYNC_CLOCK_HOLD_N_I),
            .q_o(hold_sync_n[b])
        ); // R14

        ccg_bank u_bank (
            .clk_i(CLK_I),
            .rst_n_i(RSTN_I),
            .cfg_i(s_r.cfg[b]),
            .hold_sync_n_i(hold_sync_n[b]),
            .global_en_n_i(GLOBAL_DRIVE_ENABLE_N_I),
            .first_n_i(SECONDARY_ENABLE_FIRST_N_I),
            .second_n_i(SECONDARY_ENABLE_SECOND_N_I),
            .clk_a_o(CLK_OUT_O[2*b]),
            .clk_b_o(CLK_OUT_O[2*b+1]),
            .oe_n_a_o(DRIVE_OE_N_O[2*b]),
            .oe_n_b_o(DRIVE_OE_N_O[2*b+1]),
            .slew_a_o(SLEW_O[4*b +: 2]),
            .slew_b_o(SLEW_O[4*b+2 +: 2]),
            .term_a_o(TERM_EN_O[2*b]),
            .term_b_o(TERM_EN_O[2*b+1]),
            .held_o(held[b])
        );
    end

    // ==========================================================
    // Checks
    a_gate_two_flops: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R14
        ($fell(SYNC_CLOCK_HOLD_N_I) && s_r.cfg[0][CFG_GATE_BIT]) ##1 (!SYNC_CLOCK_HOLD_N_I && $stable(s_r.cfg[0]))
        |=> !held[0])
        else $error("hold taken before two synchroniser stages");
    a_cfg_stable: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R15
        !do_write |=> $stable(s_r.cfg))
        else $error("configuration changed without a write");
    a_write_resp: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        do_write |=> (BVALID_O && !s_r.aw_held && !s_r.w_held))
        else $error("write response missing");
    a_bvalid_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
        else $error("write response dropped before taken");
    a_rvalid_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (RVALID_O && !RREADY_I) |=> (RVALID_O && $stable(RDATA_O)))
        else $error("read data dropped before taken");
    a_read_unmapped: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ar_take && !ar_mapped) |=> (RVALID_O && RRESP_O == RESP_SLVERR && RDATA_O == 32'h0000_0000))
        else $error("unmapped read not refused");

endmodule : ccg_top

/* File: logic/ccg_pkg.sv */
package ccg_pkg;

    // ==========================================================
    // Bus geometry and register map
    localparam int AXI_ADDR_W = 8;
    localparam logic [AXI_ADDR_W-1:0] OFS_DRV_STATUS = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_PIN_STATUS = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_BANK_BASE = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Per-bank configuration word layout
    localparam int CFG_W = 16;
    localparam int CFG_DIFF_BIT = 0;
    localparam int CFG_GATE_BIT = 1;
    localparam int CFG_STD_LSB = 2;
    localparam int CFG_EN0_LSB = 4;
    localparam int CFG_EN1_LSB = 6;
    localparam int CFG_POL0_BIT = 8;
    localparam int CFG_POL1_BIT = 9;
    localparam int CFG_SLEW0_LSB = 10;
    localparam int CFG_SLEW1_LSB = 12;
    localparam int CFG_TERM0_BIT = 14;
    localparam int CFG_TERM1_BIT = 15;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

    // ==========================================================
    // Status word layout
    localparam int PIN_HOLD_BIT = 0;
    localparam int PIN_GLOBAL_BIT = 1;
    localparam int PIN_FIRST_BIT = 2;
    localparam int PIN_SECOND_BIT = 3;
    localparam int PIN_HELD_LSB = 16;

    // ==========================================================
    // Modes and constants
    localparam logic [1:0] SLEW_FIXED = 2'h0;
    localparam logic SYNC_IDLE = 1'h1;

    typedef enum logic [1:0] {
        ENS_OFF,
        ENS_ON,
        ENS_FIRST,
        ENS_SECOND
    } ccg_ensrc_e;

    typedef enum logic [1:0] {
        STD_SINGLE,
        STD_SINGLE_REF,
        STD_LOWSWING_LVDS,
        STD_LOWSWING_PECL
    } ccg_std_e;

endpackage : ccg_pkg

/* File: logic/ccg_sync.sv */
module ccg_sync
    import ccg_pkg::*;
#(
    parameter int STAGES = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);

    typedef struct packed {
        logic [STAGES-1:0] sh;
    } ccg_sync_s;

    ccg_sync_s s_r;
    ccg_sync_s s_nxt;

    // ==========================================================
    // Shift chain; stage 0 feeds only stage 1
    always_comb begin
        s_nxt = s_r;
        s_nxt.sh = {s_r.sh[STAGES-2:0], d_i}; // R14
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= {STAGES{SYNC_IDLE}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.sh[STAGES-1];

endmodule : ccg_sync

/* File: logic/ccg_bank.sv */
module ccg_bank
    import ccg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [CFG_W-1:0] cfg_i,
    input wire logic hold_sync_n_i,
    input wire logic global_en_n_i,
    input wire logic first_n_i,
    input wire logic second_n_i,
    output logic clk_a_o,
    output logic clk_b_o,
    output logic oe_n_a_o,
    output logic oe_n_b_o,
    output logic [1:0] slew_a_o,
    output logic [1:0] slew_b_o,
    output logic term_a_o,
    output logic term_b_o,
    output logic held_o
);

    typedef struct packed {
        logic hold;
        logic [1:0] slew_a;
        logic [1:0] slew_b;
        logic term_a;
        logic term_b;
    } ccg_bank_s;

    ccg_bank_s s_r;
    ccg_bank_s s_nxt;
    ccg_std_e std;
    ccg_ensrc_e src_a;
    ccg_ensrc_e src_b;
    logic lowswing;
    logic diff;
    logic member;
    logic pol_a;
    logic pol_b;
    logic en_a;
    logic en_b;

    function automatic logic drive_en(input ccg_ensrc_e src, input logic g_n, input logic f_n, input logic s_n);
        logic en;
        en = 1'b0;
        if (!g_n) begin
            unique case (src)
                ENS_OFF: en = 1'b0;
                ENS_ON: en = 1'b1;
                ENS_FIRST: en = !f_n;
                ENS_SECOND: en = !s_n;
            endcase
        end
        return en;
    endfunction : drive_en

    // ==========================================================
    // Configuration decode; one standard per bank
    assign std = ccg_std_e'(cfg_i[CFG_STD_LSB +: 2]); // R3
    assign lowswing = (std == STD_LOWSWING_LVDS) || (std == STD_LOWSWING_PECL);
    assign diff = cfg_i[CFG_DIFF_BIT] | lowswing; // R2
    assign member = cfg_i[CFG_GATE_BIT];
    assign src_a = ccg_ensrc_e'(cfg_i[CFG_EN0_LSB +: 2]);
    assign src_b = ccg_ensrc_e'(cfg_i[CFG_EN1_LSB +: 2]);
    assign pol_a = cfg_i[CFG_POL0_BIT];
    // Minus leg takes the inverse of the plus leg's polarity
    assign pol_b = diff ? !pol_a : cfg_i[CFG_POL1_BIT]; // R6

    // ==========================================================
    // Driver enables; hold never touches these
    assign en_a = drive_en(src_a, global_en_n_i, first_n_i, second_n_i); // R7 R8 R9
    assign en_b = diff ? en_a : drive_en(src_b, global_en_n_i, first_n_i, second_n_i); // R7 R8 R9
    assign oe_n_a_o = !en_a; // R10
    assign oe_n_b_o = !en_b; // R10

    always_comb begin
        s_nxt = s_r;
        // Updated on the rising edge only, so a pulse is never cut short
        s_nxt.hold = member & !hold_sync_n_i; // R12 R13 R14
        s_nxt.slew_a = lowswing ? SLEW_FIXED : cfg_i[CFG_SLEW0_LSB +: 2]; // R4
        s_nxt.slew_b = lowswing ? SLEW_FIXED : cfg_i[CFG_SLEW1_LSB +: 2]; // R4
        s_nxt.term_a = lowswing ? 1'b0 : cfg_i[CFG_TERM0_BIT]; // R5
        s_nxt.term_b = lowswing ? 1'b0 : cfg_i[CFG_TERM1_BIT]; // R5
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Output levels: idle level equals the polarity bit
    assign clk_a_o = s_r.hold ? pol_a : (clk_i ^ pol_a); // R11
    assign clk_b_o = s_r.hold ? pol_b : (clk_i ^ pol_b); // R11
    assign slew_a_o = s_r.slew_a;
    assign slew_b_o = s_r.slew_b;
    assign term_a_o = s_r.term_a;
    assign term_b_o = s_r.term_b;
    assign held_o = s_r.hold;

    // ==========================================================
    // Checks
    a_global_hiz: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
        global_en_n_i |-> (oe_n_a_o && oe_n_b_o))
        else $error("driver enabled while global enable high");
    a_off_hiz: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        (src_a == ENS_OFF) |-> oe_n_a_o)
        else $error("permanently off output driven");
    a_on_drives: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        (!global_en_n_i && src_a == ENS_ON) |-> !oe_n_a_o)
        else $error("always-on output not driven");
    a_first_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
        (!global_en_n_i && src_a == ENS_FIRST) |-> (oe_n_a_o == first_n_i))
        else $error("output enable does not follow first secondary enable");
    a_hold_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        s_r.hold |-> (clk_a_o == pol_a))
        else $error("held output not at idle level");
    a_hold_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        (member && !hold_sync_n_i) |=> s_r.hold)
        else $error("hold not taken one edge after gate low");
    a_nonmember_free: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        (!member && $stable(cfg_i)) |=> !s_r.hold)
        else $error("bank outside gate group was held");
    a_lowswing_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
        (lowswing && $stable(cfg_i)) |=> (slew_a_o == SLEW_FIXED && !term_a_o && !term_b_o))
        else $error("slew or termination active in low-swing mode");
    a_diff_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
        diff |-> (clk_b_o != clk_a_o && oe_n_b_o == oe_n_a_o))
        else $error("differential legs not complementary");

endmodule : ccg_bank

/* File: testbench/ccg_board.sv */
// ==========================================================
// Board side: control-pin drivers and clock loads
module ccg_board
    import ccg_pkg::*;
#(
    parameter int N = 5
) (
    input wire logic g_i,
    input wire logic f_i,
    input wire logic s_i,
    input wire logic h_i,
    output logic global_n_o,
    output logic first_n_o,
    output logic second_n_o,
    output logic hold_n_o,
    input wire logic [2*N-1:0] clk_out_i,
    input wire logic [2*N-1:0] oe_n_i,
    output logic [2*N-1:0] line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2*N-1:0] last;

    // Prompt pin drivers
    assign global_n_o = g_i;
    assign first_n_o = f_i;
    assign second_n_o = s_i;
    assign hold_n_o = h_i;

    // Released line shows the inverse of its last level, never a lucky match
    always @* begin
        for (int i = 0; i < 2*N; i++) begin
            if (!oe_n_i[i]) begin
                line_o[i] = clk_out_i[i];
                last[i] = clk_out_i[i];
            end else begin
                line_o[i] = ~last[i];
            end
        end
    end
endmodule : ccg_board

/* File: testbench/ccg_top_tb_top.sv */
module ccg_top_tb_top
    import ccg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 5;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cg = 1'h0, cf = 1'h1, cs = 1'h1, ch = 1'h1;
    logic gn, fn, sn, hn;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata;
    logic [2*N-1:0] clko, oen, term, line;
    logic [4*N-1:0] slew;
    logic [CFG_W-1:0] cfg [N];
    int errors = 0, comparisons = 0, cycles = 0;
    int seed = 32'h976608a7;

    always #50 clk = ~clk;

    ccg_top #(.NUM_BANKS(N), .SYNC_STAGES(2)) DUT (.CLK_I(clk), .RSTN_I(rst_n),
        .GLOBAL_DRIVE_ENABLE_N_I(gn), .SECONDARY_ENABLE_FIRST_N_I(fn), .SECONDARY_ENABLE_SECOND_N_I(sn),
        .SYNC_CLOCK_HOLD_N_I(hn), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .CLK_OUT_O(clko),
        .DRIVE_OE_N_O(oen), .SLEW_O(slew), .TERM_EN_O(term));

    ccg_board #(.N(N)) board (.g_i(cg), .f_i(cf), .s_i(cs), .h_i(ch), .global_n_o(gn), .first_n_o(fn),
        .second_n_o(sn), .hold_n_o(hn), .clk_out_i(clko), .oe_n_i(oen), .line_o(line));

    // ==========================================================
    // Expectations
    function automatic logic dif(input int b);
        return cfg[b][CFG_DIFF_BIT] || cfg[b][CFG_STD_LSB+1];
    endfunction : dif

    function automatic logic [2*N-1:0] exp_oe(input logic g, f, s);
        logic [1:0] src;
        for (int i = 0; i < 2*N; i++) begin
            src = cfg[i/2][(((i % 2 == 1) && !dif(i/2)) ? CFG_EN1_LSB : CFG_EN0_LSB) +: 2];
            exp_oe[i] = g || src == ENS_OFF || (src == ENS_FIRST && f) || (src == ENS_SECOND && s);
        end
    endfunction : exp_oe

    function automatic logic [2*N-1:0] exp_clk(input logic c, h);
        logic pol;
        for (int i = 0; i < 2*N; i++) begin
            pol = cfg[i/2][CFG_POL0_BIT];
            if (i % 2 == 1) pol = dif(i/2) ? ~pol : cfg[i/2][CFG_POL1_BIT];
            exp_clk[i] = (h && cfg[i/2][CFG_GATE_BIT]) ? pol : c ^ pol;
        end
    endfunction : exp_clk

    function automatic logic [6*N-1:0] exp_st();
        for (int b = 0; b < N; b++) begin
            // Only the low-swing standards fix slew and drop termination
            exp_st[4*b +: 4] = cfg[b][CFG_STD_LSB+1] ? 4'h0 : cfg[b][CFG_SLEW0_LSB +: 4];
            exp_st[4*N+2*b +: 2] = cfg[b][CFG_STD_LSB+1] ? 2'h0 : cfg[b][CFG_TERM0_BIT +: 2];
        end
    endfunction : exp_st

    // ==========================================================
    // Checking and closing
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Limit sits far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Bus tasks: handshake flags sampled on the low phase, stable up to the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'h0;
            if (w_t) wvalid <= 1'h0;
        end while (!b_t);
        bready <= 1'h0;
    endtask : wr

    task automatic rdw(input logic [7:0] a);
        logic ar_t, r_t;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'h0;
        end while (!r_t);
        rready <= 1'h0;
    endtask : rdw

    task automatic outs(input logic h);
        logic [2*N-1:0] e;
        @(posedge clk);
        #25;
        e = exp_oe(gn, fn, sn);
        chk("drive_oe_n", oen, e);
        chk("clk_high", clko, exp_clk(1'h1, h));
        chk("load_line", line & ~e, exp_clk(1'h1, h) & ~e);
        chk("slew_term", {term, slew}, exp_st());
        #50;
        chk("clk_low", clko, exp_clk(1'h0, h));
    endtask : outs

    // ==========================================================
    // Main sequence
    initial begin
        for (int b = 0; b < N; b++) cfg[b] = CFG_RST;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        outs(1'h0);
        rdw(OFS_BANK_BASE);
        chk("cfg_reset", rd, 32'h0);
        wr(OFS_BANK_BASE + 8'(4*N), 32'hffff);
        chk("unmapped_wr", rsp, RESP_SLVERR);
        rdw(8'h08);
        chk("unmapped_rd", {rsp, rd}, {RESP_SLVERR, 32'h0});
        wr(OFS_DRV_STATUS, 32'hffff_ffff);
        chk("ro_wr", rsp, RESP_OKAY);
        for (int r = 0; r < 6; r++) begin
            for (int b = 0; b < N; b++) begin
                cfg[b] = CFG_W'($random(seed));
                if (r == 0) cfg[b][7:4] = {2'(b + 1), 2'(b)};
                wr(OFS_BANK_BASE + 8'(4*b), {16'hffff, cfg[b]});
                rdw(OFS_BANK_BASE + 8'(4*b));
                chk("cfg_read", rd, {16'h0, cfg[b]});
            end
            for (int p = 0; p < 8; p++) begin
                @(posedge clk);
                cg <= p[0];
                cf <= p[1];
                cs <= p[2];
                outs(1'h0);
            end
            // Gate low: held from the third edge, so the second still clocks
            @(posedge clk);
            cg <= 1'h0;
            cf <= 1'($random(seed));
            cs <= 1'($random(seed));
            ch <= 1'h0;
            @(posedge clk);
            outs(1'h0);
            outs(1'h1);
            rdw(OFS_PIN_STATUS);
            for (int b = 0; b < N; b++) chk("held", rd[PIN_HELD_LSB+b], cfg[b][CFG_GATE_BIT]);
            chk("pins", rd[3:0], {sn, fn, gn, 1'h0});
            rdw(OFS_DRV_STATUS);
            chk("drv_status", rd, {{(32-2*N){1'b0}}, ~exp_oe(gn, fn, sn)});
            @(posedge clk);
            ch <= 1'h1;
            @(posedge clk);
            outs(1'h1);
            outs(1'h0);
        end
        // Reset in mid-run must bring back the cleared configuration
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        for (int b = 0; b < N; b++) cfg[b] = CFG_RST;
        outs(1'h0);
        rdw(OFS_BANK_BASE + 8'(4*(N-1)));
        chk("cfg_mid_reset", {rsp, rd}, {RESP_OKAY, 32'h0});
        report_and_stop();
    end
endmodule : ccg_top_tb_top
